/* File: core/dld_pkg.sv */
// shared constants and types for the dead line detector
package dld_pkg;

	// ==========================================================
	// data widths
	localparam int MAG_W = 16;              // magnitude word width
	localparam int PCT_W = 7;               // percentage setting width
	localparam int ADR_W = 4;               // byte address width
	localparam int DAT_W = 32;              // bus data width
	localparam int NPH   = 3;               // phases per quantity

	// ==========================================================
	// register byte offsets
	localparam logic [ADR_W-1:0] REG_CTRL = 4'h0; // enable setting
	localparam logic [ADR_W-1:0] REG_VOLT = 4'h4; // voltage threshold
	localparam logic [ADR_W-1:0] REG_CURR = 4'h8; // current threshold
	localparam logic [ADR_W-1:0] REG_STAT = 4'hc; // live state, read only

	// ==========================================================
	// field positions
	localparam int CTRL_EN_BIT  = 0;        // operation on/off
	localparam int STAT_VST_LSB = 0;        // voltage starts, 3 bits
	localparam int STAT_CST_LSB = 3;        // current starts, 3 bits
	localparam int STAT_DEAD    = 6;        // dead-line flag
	localparam int STAT_LIVE    = 7;        // live-line flag
	localparam int STAT_BLK     = 8;        // block input level
	localparam int STAT_RUN     = 9;        // function running

	// ==========================================================
	// reset values and setting ranges, percent
	localparam logic             EN_RST    = 1'b0;  // off after reset
	localparam logic [PCT_W-1:0] VOLT_RST  = 7'h3c; // 60
	localparam logic [PCT_W-1:0] VOLT_MIN  = 7'h0a; // 10
	localparam logic [PCT_W-1:0] VOLT_MAX  = 7'h64; // 100
	localparam logic [PCT_W-1:0] CURR_RST  = 7'h0a; // 10
	localparam logic [PCT_W-1:0] CURR_MIN  = 7'h02; // 2
	localparam logic [PCT_W-1:0] CURR_MAX  = 7'h64; // 100
	localparam logic [PCT_W-1:0] PCT_SCALE = 7'h64; // 100 percent

	// ==========================================================
	// per-phase start flags travel together
	typedef struct packed {
		logic [NPH-1:0] volt;               // voltage above threshold
		logic [NPH-1:0] curr;               // current above threshold
	} dld_flags_t;

endpackage

/* File: core/dld_cmp.sv */
// one magnitude against a percentage of its rated value
`timescale 1ns/100ps

module dld_cmp #(
	parameter int                  MAG_W = 16,
	parameter logic [MAG_W-1:0]    NOM   = 16'h1000
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// setting and gating
	input  wire logic              run,
	input  wire logic [6:0]        pct,
	// magnitude from the preparation stage
	input  wire logic [MAG_W-1:0]  mag,
	// comparison results
	output logic                   above_q,
	output logic                   below_q
);
	import dld_pkg::*;

	localparam int W = MAG_W + PCT_W;       // product width, no overflow

	logic [W-1:0] lhs;                      // magnitude times 100
	logic [W-1:0] rhs;                      // setting times rated value

	// both sides scaled so no division is needed
	always_comb begin
		lhs = W'(mag) * W'(PCT_SCALE);
		rhs = W'(pct) * W'(NOM);
	end

	// registered flags, both low while the function is idle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			above_q <= 1'b0;
			below_q <= 1'b0;
		end else begin
			above_q <= run && (lhs > rhs);
			below_q <= run && (lhs < rhs);
		end
	end

	// ==========================================================
	// checks
	property p_above_cause;
		@(posedge clk) disable iff (sys_rst)
		above_q |-> $past(run) && ($past(lhs) > $past(rhs));
	endproperty
	a_above_cause: assert property (p_above_cause)
		else $error("start flag without magnitude above threshold");

	property p_excl;
		@(posedge clk) disable iff (sys_rst)
		!(above_q && below_q);
	endproperty
	a_excl: assert property (p_excl)
		else $error("above and below at once");

endmodule

/* File: core/dld_decide.sv */
// combines start flags, enable and block into line state
`timescale 1ns/100ps

module dld_decide (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// gating
	input  wire logic                     run,
	// per-phase comparison results
	input  wire dld_pkg::dld_flags_t      start,
	input  wire logic [2:0]               vbelow,
	input  wire logic [2:0]               cbelow,
	// line state
	output logic                          dead_q,
	output logic                          live_q
);
	import dld_pkg::*;

	// line state from the six below flags and the three voltage starts plus gating
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dead_q <= 1'b0;
			live_q <= 1'b0;
		end else begin
			dead_q <= run && (&vbelow) && (&cbelow);
			live_q <= run && (&start.volt);
		end
	end

	// ==========================================================
	// checks
	property p_dead;
		@(posedge clk) disable iff (sys_rst)
		$past(run && (&vbelow) && (&cbelow)) |-> dead_q;
	endproperty
	a_dead: assert property (p_dead)
		else $error("dead-line not raised on all-low quantities");

	property p_live;
		@(posedge clk) disable iff (sys_rst)
		live_q |-> $past(run) && ($past(start.volt) == 3'h7) && !dead_q;
	endproperty
	a_live: assert property (p_live)
		else $error("live-line without all voltages high");

	// dead-line never coexists with any start flag of the cycle before
	property p_dead_quiet;
		@(posedge clk) disable iff (sys_rst)
		dead_q |-> ($past(start) == '0);
	endproperty
	a_dead_quiet: assert property (p_dead_quiet)
		else $error("dead-line raised while a start flag was set");

endmodule

/* File: core/dld_top.sv */
// dead line detector: threshold stage, decision stage, register slave
`timescale 1ns/100ps

module dld_top #(
	parameter int                         MAG_W    = 16,
	parameter logic [MAG_W-1:0]           NOM_VOLT = 16'h1000,
	parameter logic [MAG_W-1:0]           NOM_CURR = 16'h1000
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// avalon-mm slave
	input  wire logic [dld_pkg::ADR_W-1:0] avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [dld_pkg::DAT_W-1:0] avs_writedata,
	output logic [dld_pkg::DAT_W-1:0]     avs_readdata,
	output logic                          avs_waitrequest,
	// fundamental magnitudes from the preparation stage
	input  wire logic [MAG_W-1:0]         volt_mag_ph1,
	input  wire logic [MAG_W-1:0]         volt_mag_ph2,
	input  wire logic [MAG_W-1:0]         volt_mag_ph3,
	input  wire logic [MAG_W-1:0]         curr_mag_ph1,
	input  wire logic [MAG_W-1:0]         curr_mag_ph2,
	input  wire logic [MAG_W-1:0]         curr_mag_ph3,
	// user block input
	input  wire logic                     detector_block_in,
	// start flags
	output logic                          volt_start_ph1,
	output logic                          volt_start_ph2,
	output logic                          volt_start_ph3,
	output logic                          curr_start_ph1,
	output logic                          curr_start_ph2,
	output logic                          curr_start_ph3,
	// line state
	output logic                          dead_line_flag,
	output logic                          live_line_flag
);
	import dld_pkg::*;

	// ==========================================================
	// settings and internal state
	logic             enable_q;             // operation setting
	logic [PCT_W-1:0] volt_pct_q;           // voltage threshold, percent
	logic [PCT_W-1:0] curr_pct_q;           // current threshold, percent
	logic             wait_q;               // waitrequest register
	logic [DAT_W-1:0] rdata_q;              // read data register
	logic             run;                  // function active
	logic             req;                  // bus request present
	logic             take;                 // request completes this edge
	logic             aligned;              // word-aligned address
	logic [MAG_W-1:0] vmag [NPH];           // voltage magnitudes
	logic [MAG_W-1:0] cmag [NPH];           // current magnitudes
	dld_flags_t       start;                // start flags
	logic [NPH-1:0]   vbelow;               // voltage below threshold
	logic [NPH-1:0]   cbelow;               // current below threshold
	logic [DAT_W-1:0] status;               // status word
	logic [DAT_W-1:0] rmux;                 // read mux

	// clamp a written value into the allowed setting range
	function automatic logic [PCT_W-1:0] clamp_pct(
		input logic [DAT_W-1:0] v,
		input logic [PCT_W-1:0] lo,
		input logic [PCT_W-1:0] hi
	);
		logic [PCT_W-1:0] r;
		r = v[PCT_W-1:0];
		if (v < DAT_W'(lo)) begin
			r = lo;
		end else if (v > DAT_W'(hi)) begin
			r = hi;
		end
		return r;
	endfunction

	// ==========================================================
	// gating and bus decode
	always_comb begin
		run     = enable_q && !detector_block_in;
		req     = avs_read || avs_write;
		take    = req && !wait_q;
		aligned = (avs_address[1:0] == 2'b00);
		vmag[0] = volt_mag_ph1;
		vmag[1] = volt_mag_ph2;
		vmag[2] = volt_mag_ph3;
		cmag[0] = curr_mag_ph1;
		cmag[1] = curr_mag_ph2;
		cmag[2] = curr_mag_ph3;
	end

	// ==========================================================
	// threshold stage, one comparator per phase and quantity
	genvar g;
	generate
		for (g = 0; g < NPH; g++) begin : g_ph
			dld_cmp #(
				.MAG_W   (MAG_W),
				.NOM     (NOM_VOLT)
			) u_vcmp (
				.clk     (clk),
				.sys_rst (sys_rst),
				.run     (run),
				.pct     (volt_pct_q),
				.mag     (vmag[g]),
				.above_q (start.volt[g]),
				.below_q (vbelow[g])
			);
			dld_cmp #(
				.MAG_W   (MAG_W),
				.NOM     (NOM_CURR)
			) u_ccmp (
				.clk     (clk),
				.sys_rst (sys_rst),
				.run     (run),
				.pct     (curr_pct_q),
				.mag     (cmag[g]),
				.above_q (start.curr[g]),
				.below_q (cbelow[g])
			);
		end
	endgenerate

	// ==========================================================
	// decision stage
	dld_decide u_decide (
		.clk     (clk),
		.sys_rst (sys_rst),
		.run     (run),
		.start   (start),
		.vbelow  (vbelow),
		.cbelow  (cbelow),
		.dead_q  (dead_line_flag),
		.live_q  (live_line_flag)
	);

	// start flags leave straight from the comparator flops
	always_comb begin
		volt_start_ph1 = start.volt[0];
		volt_start_ph2 = start.volt[1];
		volt_start_ph3 = start.volt[2];
		curr_start_ph1 = start.curr[0];
		curr_start_ph2 = start.curr[1];
		curr_start_ph3 = start.curr[2];
	end

	// ==========================================================
	// settings registers, written on the completing edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable_q   <= EN_RST;
			volt_pct_q <= VOLT_RST;
			curr_pct_q <= CURR_RST;
		end else if (take && avs_write && aligned) begin
			case (avs_address)
				REG_CTRL: begin
					enable_q <= avs_writedata[CTRL_EN_BIT];
				end
				REG_VOLT: begin
					// out-of-range values pinned to the nearest end
					volt_pct_q <= clamp_pct(avs_writedata,
						VOLT_MIN, VOLT_MAX);
				end
				REG_CURR: begin
					curr_pct_q <= clamp_pct(avs_writedata,
						CURR_MIN, CURR_MAX);
				end
				default: begin
					// status and unmapped writes are ignored
				end
			endcase
		end
	end

	// ==========================================================
	// status word: flags only, nothing is logged here
	always_comb begin
		status = '0;
		status[STAT_VST_LSB +: NPH] = start.volt;
		status[STAT_CST_LSB +: NPH] = start.curr;
		status[STAT_DEAD]           = dead_line_flag;
		status[STAT_LIVE]           = live_line_flag;
		status[STAT_BLK]            = detector_block_in;
		status[STAT_RUN]            = run;
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rmux = '0;
		if (aligned) begin
			case (avs_address)
				REG_CTRL: rmux = DAT_W'(enable_q);
				REG_VOLT: rmux = DAT_W'(volt_pct_q);
				REG_CURR: rmux = DAT_W'(curr_pct_q);
				REG_STAT: rmux = status;
				default:  rmux = '0;
			endcase
		end
	end

	// ==========================================================
	// one wait cycle per access: high at request, low one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !(req && wait_q);
		end
	end

	// read data captured while waitrequest is still high
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= '0;
		end else if (avs_read && wait_q) begin
			rdata_q <= rmux;
		end
	end

	always_comb begin
		avs_waitrequest = wait_q;
		avs_readdata    = rdata_q;
	end

	// ==========================================================
	// checks
	property p_reset_vals;
		@(posedge clk)
		$past(sys_rst) |-> !enable_q && (volt_pct_q == VOLT_RST)
			&& (curr_pct_q == CURR_RST);
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("settings not at reset values");

	property p_volt_range;
		@(posedge clk) disable iff (sys_rst)
		(volt_pct_q >= VOLT_MIN) && (volt_pct_q <= VOLT_MAX);
	endproperty
	a_volt_range: assert property (p_volt_range)
		else $error("voltage threshold outside range");

	property p_curr_clamp;
		@(posedge clk) disable iff (sys_rst)
		take && avs_write && (avs_address == REG_CURR)
			&& (avs_writedata < 32'h2) |=> (curr_pct_q == CURR_MIN);
	endproperty
	a_curr_clamp: assert property (p_curr_clamp)
		else $error("low current threshold not pinned to minimum");

	property p_idle_outputs;
		@(posedge clk) disable iff (sys_rst)
		!run |=> (start == '0) ##1 !(dead_line_flag || live_line_flag);
	endproperty
	a_idle_outputs: assert property (p_idle_outputs)
		else $error("outputs active while disabled or blocked");

	property p_bus_answer;
		@(posedge clk) disable iff (sys_rst)
		req && wait_q |=> !wait_q ##1 wait_q;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("waitrequest did not drop for exactly one cycle");

	property p_dead_live_excl;
		@(posedge clk) disable iff (sys_rst)
		!(dead_line_flag && live_line_flag);
	endproperty
	a_dead_live_excl: assert property (p_dead_live_excl)
		else $error("dead-line and live-line together");

	// the enable bit follows the completed control write
	property p_enable_write;
		@(posedge clk) disable iff (sys_rst)
		take && avs_write && (avs_address == REG_CTRL)
			|=> (enable_q == $past(avs_writedata[CTRL_EN_BIT]));
	endproperty
	a_enable_write: assert property (p_enable_write)
		else $error("enable setting did not take the written bit");

	// an over-range voltage write lands on the top of the range
	property p_volt_clamp;
		@(posedge clk) disable iff (sys_rst)
		take && avs_write && (avs_address == REG_VOLT)
			&& (avs_writedata > DAT_W'(VOLT_MAX))
			|=> (volt_pct_q == VOLT_MAX);
	endproperty
	a_volt_clamp: assert property (p_volt_clamp)
		else $error("high voltage threshold not pinned to maximum");

	// status is read only, a write to it leaves every setting alone
	property p_stat_ro;
		@(posedge clk) disable iff (sys_rst)
		take && avs_write && (avs_address == REG_STAT)
			|=> $stable(enable_q) && $stable(volt_pct_q)
			&& $stable(curr_pct_q);
	endproperty
	a_stat_ro: assert property (p_stat_ro)
		else $error("write to status changed a setting");

endmodule

/* File: testbench/dld_mag_src.sv */
// model of the preparation stage feeding per-phase magnitudes
`timescale 1ns/100ps

module dld_mag_src (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// magnitudes the bench asks for
	input  wire logic [15:0] vset [3],
	input  wire logic [15:0] cset [3],
	// magnitudes handed to the detector
	output logic      [15:0] vmag [3],
	output logic      [15:0] cmag [3]
);
	// ==========================================================
	// one fresh fundamental magnitude per phase each sample tick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vmag <= '{default: 16'h0000};
			cmag <= '{default: 16'h0000};
		end else begin
			vmag <= vset;
			cmag <= cset;
		end
	end
endmodule

/* File: testbench/dead_line_detector_tb.sv */
// self-checking bench for the dead line detector
`timescale 1ns/100ps

module dead_line_detector_tb;
	import dld_pkg::*;

	// ==========================================================
	// signals
	localparam logic [15:0] NOM = 16'h1000; // rated magnitude
	logic             clk;       // system clock
	logic             sys_rst;   // synchronous reset
	logic [ADR_W-1:0] adr;       // bus address
	logic             rd;        // read request
	logic             wr;        // write request
	logic [DAT_W-1:0] wdat;      // write data
	logic [DAT_W-1:0] rdat;      // read data
	logic             wait_req;  // slave stall
	logic [15:0]      vset [3];  // requested voltages
	logic [15:0]      cset [3];  // requested currents
	logic [15:0]      vmag [3];  // voltages at the detector
	logic [15:0]      cmag [3];  // currents at the detector
	logic             blk;       // user block input
	logic [2:0]       vst;       // voltage starts
	logic [2:0]       cst;       // current starts
	logic             dead;      // dead-line flag
	logic             live;      // live-line flag
	int               n_fail;    // mismatches
	int               cmp_count; // comparisons
	logic             en_m;      // expected enable
	logic [PCT_W-1:0] vp_m;      // expected voltage threshold
	logic [PCT_W-1:0] cp_m;      // expected current threshold

	// ==========================================================
	// design and upstream model
	dld_top #(.MAG_W(16), .NOM_VOLT(NOM), .NOM_CURR(NOM)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
		.avs_waitrequest(wait_req), .volt_mag_ph1(vmag[0]),
		.volt_mag_ph2(vmag[1]), .volt_mag_ph3(vmag[2]),
		.curr_mag_ph1(cmag[0]), .curr_mag_ph2(cmag[1]),
		.curr_mag_ph3(cmag[2]), .detector_block_in(blk),
		.volt_start_ph1(vst[0]), .volt_start_ph2(vst[1]),
		.volt_start_ph3(vst[2]), .curr_start_ph1(cst[0]),
		.curr_start_ph2(cst[1]), .curr_start_ph3(cst[2]),
		.dead_line_flag(dead), .live_line_flag(live)
	);
	dld_mag_src src_u (
		.clk(clk), .sys_rst(sys_rst), .vset(vset), .cset(cset),
		.vmag(vmag), .cmag(cmag)
	);

	// ==========================================================
	// checking and closing
	task automatic check(input logic [DAT_W-1:0] seen,
		input logic [DAT_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================================
	// avalon-mm master: hold the request until waitrequest is low
	task automatic bus(input logic w, input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] q);
		int i;
		@(posedge clk);
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wait_req === 1'b0) break;
		end
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 20) begin
			n_fail++;
			summarize();
		end
	endtask

	task automatic wreg(input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] d);
		logic [DAT_W-1:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rchk(input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] e);
		logic [DAT_W-1:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(q, e);
	endtask

	// ==========================================================
	// apply {block, c3, c2, c1, v3, v2, v1}, settle, compare all flags
	task automatic line(input logic [96:0] t);
		logic       run;
		logic [2:0] ev;
		logic [2:0] ec;
		logic [2:0] vl;
		logic [2:0] cl;
		logic       de;
		logic [DAT_W-1:0] st;
		for (int i = 0; i < 3; i++) begin
			vset[i] <= t[16*i +: 16];
			cset[i] <= t[48+16*i +: 16];
		end
		blk <= t[96];
		repeat (5) @(posedge clk);
		run = en_m & ~t[96];
		for (int i = 0; i < 3; i++) begin
			ev[i] = run & (int'(vset[i]) * 100 > int'(vp_m) * int'(NOM));
			ec[i] = run & (int'(cset[i]) * 100 > int'(cp_m) * int'(NOM));
			vl[i] = int'(vset[i]) * 100 < int'(vp_m) * int'(NOM);
			cl[i] = int'(cset[i]) * 100 < int'(cp_m) * int'(NOM);
		end
		de = run & (&vl) & (&cl);
		st = {22'h0, run, t[96], &ev, de, ec, ev};
		check(32'(vst), 32'(ev));
		check(32'(cst), 32'(ec));
		check(32'(dead), 32'(de));
		check(32'(live), 32'(&ev));
		rchk(REG_STAT, st);
	endtask

	// ==========================================================
	// test cases at the reset thresholds (60 and 10 percent)
	localparam logic [15:0] VH = 16'h099a; // just above 60 percent
	localparam logic [15:0] VL = 16'h0999; // just below 60 percent
	localparam logic [15:0] CH = 16'h019a; // just above 10 percent
	localparam logic [15:0] CL = 16'h0199; // just below 10 percent
	localparam logic [96:0] TC [7] = '{
		{1'b0, CL, CL, CL, VL, VL, VL},
		{1'b0, CL, CL, CL, VH, VH, VH},
		{1'b0, 16'hffff, CH, CH, VH, VH, VH},
		{1'b0, CL, CL, CL, VL, VL, VH},
		{1'b0, CL, CH, CL, VL, VL, VL},
		{1'b1, CL, CL, CL, VH, VH, VH},
		{1'b0, CL, CL, CL, VH, VL, VL}
	};

	// ==========================================================
	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		adr = '0;
		rd = 1'b0;
		wr = 1'b0;
		wdat = '0;
		blk = 1'b0;
		vset = '{default: 16'h0000};
		cset = '{default: 16'h0000};
		n_fail = 0;
		cmp_count = 0;
		en_m = EN_RST;
		vp_m = VOLT_RST;
		cp_m = CURR_RST;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(REG_CTRL, 32'h0000_0000);
		rchk(REG_VOLT, 32'h0000_003c);
		rchk(REG_CURR, 32'h0000_000a);
		rchk(4'h2, 32'h0000_0000);
		line(TC[1]);
		wreg(REG_CTRL, 32'h0000_0001);
		en_m = 1'b1;
		for (int k = 0; k < 7; k++) begin
			line(TC[k]);
		end
		wreg(REG_VOLT, 32'h0000_00c8);
		rchk(REG_VOLT, 32'h0000_0064);
		wreg(REG_VOLT, 32'h0000_0064);
		vp_m = 7'h64;
		line({1'b0, CL, CL, CL, NOM, NOM, NOM});
		wreg(REG_VOLT, 32'h0000_0009);
		vp_m = VOLT_MIN;
		rchk(REG_VOLT, 32'h0000_000a);
		wreg(REG_CURR, 32'h0000_0001);
		cp_m = CURR_MIN;
		rchk(REG_CURR, 32'h0000_0002);
		wreg(REG_STAT, 32'hffff_ffff);
		rchk(REG_CTRL, 32'h0000_0001);
		line({1'b0, 16'h0051, 16'h0051, 16'h0052, CH, CH, CH});
		line({1'b0, 16'h0051, 16'h0051, 16'h0051, 16'h0199, CL, CL});
		wreg(REG_CTRL, 32'h0000_0000);
		en_m = 1'b0;
		line(TC[0]);
		summarize();
	end
endmodule
